// *** hdl/e1_rx_perf_monitor_status.sv ***
// Purpose: receive performance counters and alarm latch behind APB
// Assumes: event pulses and line bits are synchronous to CORE_CLK
// Notes:   zero wait state slave; read data is captured at setup
`timescale 1ns/1ps

module e1_rx_perf_monitor_status #(
   parameter int AW = 8
) (
   // clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   RST,
   // apb slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [AW-1:0]          PADDR,
   input  wire logic [31:0]            PWDATA,
   input  wire logic [3:0]             PSTRB,
   output logic                        PREADY,
   output logic [31:0]                 PRDATA,
   output logic                        PSLVERR,
   // receive path events and line bits
   input  wire rx_pm_pkg::rx_events_s  RX_EVENTS,
   input  wire logic                   RX_BIT_VALID,
   input  wire logic                   RX_BIT,
   // status
   output logic                        LOSS_OF_SIGNAL,
   output logic                        AUX_PATTERN_SEEN,
   output logic                        COUNT_WRAP_IRQ
);

   typedef struct packed {
      logic [7:0]  pattern_error_count;
      logic [7:0]  pattern_multiframe_count;
      logic [7:0]  alarm_event_latch;
      logic [7:0]  errored_alignment_count;
      logic [9:0]  far_end_count;
      logic [15:0] violation_count;
      logic [9:0]  checksum_count;
      logic [7:0]  wrap_events;
      logic [7:0]  wrap_latch;
      logic [7:0]  wrap_mask;
      logic [7:0]  zero_run;
      logic        los;
      logic        in_win;
      logic [7:0]  win_cnt;
      logic [7:0]  win_ones;
      logic [9:0]  alt_cnt;
      logic        last_bit;
      logic        aux;
      logic [7:0]  rdata;
      logic        err;
   } state_s;

   state_s q;
   state_s d;

   logic [5:0] idx;
   logic       addr_ok;
   logic       setup;
   logic       acc_wr;
   logic       acc_rd;
   logic [7:0] rd_byte;
   logic       rd_ok;
   logic [7:0] set_alm;
   logic [7:0] wrap;
   logic [7:0] ones_nx;
   logic       alt;

   // last count value before the loss and auxiliary thresholds trip
   localparam logic [7:0] LOS_LAST = rx_pm_pkg::LOS_ZERO_RUN - 8'h01;
   localparam logic [9:0] AUX_LAST = rx_pm_pkg::AUX_RUN - 10'h001;

   assign idx     = PADDR[7:2];
   // shift instead of a part-select so AW = 8 leaves no empty range
   assign addr_ok = ((PADDR >> 8) == '0);
   assign setup   = PSEL & ~PENABLE;
   assign acc_wr  = PSEL & PENABLE & PWRITE;
   assign acc_rd  = PSEL & PENABLE & ~PWRITE;

   // zero wait states: every access completes in one access cycle
   assign PREADY  = 1'b1;
   assign PRDATA  = {24'h000000, q.rdata};
   assign PSLVERR = PSEL & PENABLE & q.err;

   assign LOSS_OF_SIGNAL   = q.los;
   assign AUX_PATTERN_SEEN = q.aux;
   assign COUNT_WRAP_IRQ   = |q.wrap_events;

   // read multiplexer, unused bits zero
   always_comb begin
      rd_byte = 8'h00;
      rd_ok   = addr_ok;
      unique case (idx)
         rx_pm_pkg::IDX_PATTERN_ERR:
            rd_byte = q.pattern_error_count;
         rx_pm_pkg::IDX_PATTERN_MF:
            rd_byte = q.pattern_multiframe_count;
         rx_pm_pkg::IDX_ALARM_LATCH:
            rd_byte = q.alarm_event_latch;
         rx_pm_pkg::IDX_ALIGN_ERR:
            rd_byte = q.errored_alignment_count;
         rx_pm_pkg::IDX_FAR_END_HI:
            rd_byte = {6'h00, q.far_end_count[9:8]};
         rx_pm_pkg::IDX_FAR_END_LO:
            rd_byte = q.far_end_count[7:0];
         rx_pm_pkg::IDX_VIOLATION_HI:
            rd_byte = q.violation_count[15:8];
         rx_pm_pkg::IDX_VIOLATION_LO:
            rd_byte = q.violation_count[7:0];
         rx_pm_pkg::IDX_CHECKSUM_HI:
            rd_byte = {6'h00, q.checksum_count[9:8]};
         rx_pm_pkg::IDX_CHECKSUM_LO:
            rd_byte = q.checksum_count[7:0];
         rx_pm_pkg::IDX_SYNC_EVENTS,
         rx_pm_pkg::IDX_ERROR_EVENTS,
         rx_pm_pkg::IDX_TIMER_EVENTS:
            rd_byte = 8'h00;
         rx_pm_pkg::IDX_WRAP_EVENTS:
            rd_byte = q.wrap_events;
         rx_pm_pkg::IDX_WRAP_LATCH:
            rd_byte = q.wrap_latch;
         rx_pm_pkg::IDX_WRAP_MASK:
            rd_byte = q.wrap_mask;
         default:
            rd_ok = 1'b0;
      endcase
   end

   always_comb begin
      d       = q;
      set_alm = 8'h00;
      wrap    = 8'h00;
      ones_nx = 8'h00;
      alt     = 1'b0;

      // bus: capture read data at setup so the bus sees a flop
      if (setup) begin
         d.rdata = rd_byte;
         d.err   = ~rd_ok;
      end

      // pattern test counters
      if (RX_EVENTS.pattern_error) begin
         d.pattern_error_count = q.pattern_error_count + 8'h01;
         wrap[rx_pm_pkg::WRP_PATTERN] = &q.pattern_error_count;
      end
      if (RX_EVENTS.crc_multiframe) begin
         d.pattern_multiframe_count =
            q.pattern_multiframe_count + 8'h01;
         wrap[rx_pm_pkg::WRP_PAT_MF] = &q.pattern_multiframe_count;
      end

      // frame alignment errors
      if (RX_EVENTS.errored_alignment) begin
         d.errored_alignment_count =
            q.errored_alignment_count + 8'h01;
         wrap[rx_pm_pkg::WRP_ALIGN] = &q.errored_alignment_count;
      end

      // far-end block errors
      if (RX_EVENTS.far_end_error) begin
         d.far_end_count = q.far_end_count + 10'h001;
         wrap[rx_pm_pkg::WRP_FAR_END] = &q.far_end_count;
      end

      // line code violations
      if (RX_EVENTS.line_violation) begin
         d.violation_count = q.violation_count + 16'h0001;
         wrap[rx_pm_pkg::WRP_VIOL] = &q.violation_count;
      end

      // checksum errors
      if (RX_EVENTS.checksum_error) begin
         d.checksum_count = q.checksum_count + 10'h001;
         wrap[rx_pm_pkg::WRP_CHECKSUM] = &q.checksum_count;
      end

      // a write to the pattern count stores it and restarts the
      // multiframe base; the write beats a same-cycle increment
      if (acc_wr && addr_ok && idx == rx_pm_pkg::IDX_PATTERN_ERR) begin
         if (PSTRB[0]) begin
            d.pattern_error_count = PWDATA[7:0];
         end
         d.pattern_multiframe_count = rx_pm_pkg::RST_BYTE;
      end
      if (acc_wr && addr_ok && idx == rx_pm_pkg::IDX_WRAP_MASK) begin
         if (PSTRB[0]) begin
            d.wrap_mask = PWDATA[7:0];
         end
      end

      // loss of signal: zero run, then pulse-started ones window
      if (RX_BIT_VALID) begin
         if (!q.los) begin
            if (RX_BIT) begin
               d.zero_run = 8'h00;
            end else if (q.zero_run == LOS_LAST) begin
               d.los      = 1'b1;
               d.zero_run = 8'h00;
               d.in_win   = 1'b0;
               set_alm[rx_pm_pkg::ALM_LOS] = 1'b1;
            end else begin
               d.zero_run = q.zero_run + 8'h01;
            end
         end else if (q.in_win) begin
            ones_nx    = q.win_ones + {7'h00, RX_BIT};
            d.win_ones = ones_nx;
            d.win_cnt  = q.win_cnt + 8'h01;
            if (q.win_cnt == LOS_LAST) begin
               d.in_win = 1'b0;
               // too sparse: wait for the next pulse to retry
               if (ones_nx >= rx_pm_pkg::LOS_MIN_ONES) begin
                  d.los = 1'b0;
               end
            end
         end else if (RX_BIT) begin
            d.in_win   = 1'b1;
            d.win_cnt  = 8'h01;
            d.win_ones = 8'h01;
         end

         // auxiliary pattern: alternating run, saturating count
         alt        = RX_BIT ^ q.last_bit;
         d.last_bit = RX_BIT;
         if (!alt) begin
            d.alt_cnt = 10'h001;
            d.aux     = 1'b0;
         end else if (q.alt_cnt != rx_pm_pkg::AUX_RUN) begin
            d.alt_cnt = q.alt_cnt + 10'h001;
            if (q.alt_cnt == AUX_LAST) begin
               d.aux = 1'b1;
               set_alm[rx_pm_pkg::ALM_AUX] = 1'b1;
            end
         end
      end

      // alarm events into the latch
      set_alm[rx_pm_pkg::ALM_REMOTE]   = RX_EVENTS.remote_alarm;
      set_alm[rx_pm_pkg::ALM_ALL_ONES] = RX_EVENTS.all_ones_alarm;
      set_alm[rx_pm_pkg::ALM_SLOT16]   =
         RX_EVENTS.slot16_all_ones_alarm;
      set_alm[rx_pm_pkg::ALM_MFRAME]   = RX_EVENTS.multiframe_alarm;
      set_alm[rx_pm_pkg::ALM_SLIP]     =
         RX_EVENTS.receive_slip_event;

      // clear only what the read returned; a new event always wins
      if (acc_rd && addr_ok && idx == rx_pm_pkg::IDX_ALARM_LATCH) begin
         d.alarm_event_latch =
            (q.alarm_event_latch & ~q.rdata) | set_alm;
      end else begin
         d.alarm_event_latch = q.alarm_event_latch | set_alm;
      end

      // wrap reporting: unmasked events and raw latch, read clears
      if (acc_rd && addr_ok && idx == rx_pm_pkg::IDX_WRAP_EVENTS) begin
         d.wrap_events =
            (q.wrap_events & ~q.rdata) | (wrap & q.wrap_mask);
      end else begin
         d.wrap_events = q.wrap_events | (wrap & q.wrap_mask);
      end
      if (acc_rd && addr_ok && idx == rx_pm_pkg::IDX_WRAP_LATCH) begin
         d.wrap_latch = (q.wrap_latch & ~q.rdata) | wrap;
      end else begin
         d.wrap_latch = q.wrap_latch | wrap;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         q           <= '0;
         q.wrap_mask <= rx_pm_pkg::RST_WRAP_MASK;
      end else begin
         q <= d;
      end
   end

endmodule : e1_rx_perf_monitor_status

// *** hdl/rx_pm_pkg.sv ***
// Purpose: shared constants and carriers of the receive status page
// Assumes: registers are byte wide, one per aligned 32-bit APB word
// Notes:   byte address of a register is four times its index
package rx_pm_pkg;

   // register indices; byte address = index * 4
   localparam logic [5:0] IDX_PATTERN_ERR   = 6'h10;
   localparam logic [5:0] IDX_PATTERN_MF    = 6'h11;
   localparam logic [5:0] IDX_ALARM_LATCH   = 6'h12;
   localparam logic [5:0] IDX_ALIGN_ERR     = 6'h13;
   localparam logic [5:0] IDX_FAR_END_HI    = 6'h14;
   localparam logic [5:0] IDX_FAR_END_LO    = 6'h15;
   localparam logic [5:0] IDX_VIOLATION_HI  = 6'h16;
   localparam logic [5:0] IDX_VIOLATION_LO  = 6'h17;
   localparam logic [5:0] IDX_CHECKSUM_HI   = 6'h18;
   localparam logic [5:0] IDX_CHECKSUM_LO   = 6'h19;
   localparam logic [5:0] IDX_UNUSED        = 6'h1a;
   localparam logic [5:0] IDX_SYNC_EVENTS   = 6'h1b;
   localparam logic [5:0] IDX_ERROR_EVENTS  = 6'h1c;
   localparam logic [5:0] IDX_WRAP_EVENTS   = 6'h1d;
   localparam logic [5:0] IDX_TIMER_EVENTS  = 6'h1e;
   localparam logic [5:0] IDX_WRAP_LATCH    = 6'h1f;
   localparam logic [5:0] IDX_WRAP_MASK     = 6'h20;

   // alarm latch bit positions
   localparam int ALM_REMOTE   = 7;
   localparam int ALM_ALL_ONES = 6;
   localparam int ALM_SLOT16   = 5;
   localparam int ALM_LOS      = 4;
   localparam int ALM_AUX      = 3;
   localparam int ALM_MFRAME   = 2;
   localparam int ALM_SLIP     = 1;

   // wrap event bit positions
   localparam int WRP_ALIGN    = 7;
   localparam int WRP_CHECKSUM = 6;
   localparam int WRP_FAR_END  = 5;
   localparam int WRP_VIOL     = 3;
   localparam int WRP_PATTERN  = 2;
   localparam int WRP_PAT_MF   = 1;

   // reset values
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] RST_WRAP_MASK = 8'h00;

   // line condition thresholds in bit periods
   localparam logic [7:0] LOS_ZERO_RUN = 8'hc0;
   localparam logic [7:0] LOS_MIN_ONES = 8'h18;
   localparam logic [9:0] AUX_RUN      = 10'h200;

   // one-cycle event pulses from the receive path
   typedef struct packed {
      logic pattern_error;
      logic crc_multiframe;
      logic remote_alarm;
      logic all_ones_alarm;
      logic slot16_all_ones_alarm;
      logic multiframe_alarm;
      logic receive_slip_event;
      logic errored_alignment;
      logic far_end_error;
      logic line_violation;
      logic checksum_error;
   } rx_events_s;

endpackage : rx_pm_pkg

// *** tb/e1_rx_pm_chk.sv ***
// Purpose: port checks of the receive status page
// Assumes: zero wait state APB slave, one byte per word
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module e1_rx_pm_chk #(
   parameter int AW = 8
) (
   // clock and reset
   input wire logic          CORE_CLK,
   input wire logic          RST,
   // apb
   input wire logic          PSEL,
   input wire logic          PENABLE,
   input wire logic [AW-1:0] PADDR,
   input wire logic          PREADY,
   input wire logic [31:0]   PRDATA,
   input wire logic          PSLVERR,
   // line and status
   input wire logic          RX_BIT_VALID,
   input wire logic          RX_BIT,
   input wire logic          LOSS_OF_SIGNAL,
   input wire logic          AUX_PATTERN_SEEN,
   input wire logic          COUNT_WRAP_IRQ
);
   wire logic       acc = PSEL && PENABLE;
   wire logic [5:0] idx = PADDR[7:2];
   logic            last_q;
   logic            seen_q;

   // previous valid line bit, so a repeat can be spotted
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         last_q <= 1'b0;
         seen_q <= 1'b0;
      end else if (RX_BIT_VALID) begin
         last_q <= RX_BIT;
         seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   ready_in_access_a: assert property (acc |-> PREADY)
      else $error("access phase without ready");
   unused_slot_err_a: assert property (
      acc && idx == rx_pm_pkg::IDX_UNUSED |-> PSLVERR && PRDATA == 32'h0)
      else $error("unused slot not refused");
   mapped_okay_a: assert property (
      acc && idx >= 6'h10 && idx <= 6'h20 && idx != 6'h1a |-> !PSLVERR)
      else $error("mapped register refused");
   upper_bytes_zero_a: assert property (acc |-> PRDATA[31:8] == 24'h0)
      else $error("read data upper bytes set");
   far_end_unused_a: assert property (
      acc && idx == rx_pm_pkg::IDX_FAR_END_HI |-> PRDATA[7:2] == 6'h0)
      else $error("far end high unused bits set");
   checksum_unused_a: assert property (
      acc && idx == rx_pm_pkg::IDX_CHECKSUM_HI |-> PRDATA[7:2] == 6'h0)
      else $error("checksum high unused bits set");
   alarm_bit_zero_a: assert property (
      acc && idx == rx_pm_pkg::IDX_ALARM_LATCH |-> !PRDATA[0])
      else $error("alarm latch bit 0 set");
   reset_clears_a: assert property ($fell(RST) |-> PRDATA == 32'h0 &&
      !LOSS_OF_SIGNAL && !AUX_PATTERN_SEEN && !COUNT_WRAP_IRQ)
      else $error("outputs not clear after reset");
   one_blocks_loss_a: assert property (
      !LOSS_OF_SIGNAL && RX_BIT_VALID && RX_BIT |=> !LOSS_OF_SIGNAL)
      else $error("loss entered on a one");
   repeat_drops_aux_a: assert property (
      RX_BIT_VALID && seen_q && RX_BIT == last_q |=> !AUX_PATTERN_SEEN)
      else $error("aux pattern kept after repeated bit");

   cover property (acc && PSLVERR);
   cover property ($rose(LOSS_OF_SIGNAL));
   cover property ($rose(AUX_PATTERN_SEEN));
   cover property ($rose(COUNT_WRAP_IRQ));
endmodule : e1_rx_pm_chk

// *** tb/e1_rx_perf_monitor_status_test.sv ***
// Purpose: directed bench of the receive status page
// Assumes: zero wait state slave, byte per aligned word
// Notes:   counts checked after bursts of held event pulses
`timescale 1ns/1ps
module e1_rx_perf_monitor_status_test;
   logic                  clk, rst, psel, penable, pwrite, bit_v, bit_d;
   logic [7:0]            paddr, rd;
   logic [31:0]           pwdata, prdata;
   logic [3:0]            pstrb;
   logic                  pready, pslverr, er, los, aux, irq;
   rx_pm_pkg::rx_events_s ev;
   int                    fails, checked;
   int                    cycles = 0;

   e1_rx_perf_monitor_status DUT (
      .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .RX_EVENTS(ev), .RX_BIT_VALID(bit_v), .RX_BIT(bit_d),
      .LOSS_OF_SIGNAL(los), .AUX_PATTERN_SEEN(aux), .COUNT_WRAP_IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // whole run needs about 3650 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // request held until the rising edge at which ready is seen high
   task automatic xfer(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic rchk(input logic [5:0] idx, input logic [7:0] exp,
                       input logic e);
      xfer(1'b0, idx, 8'h00);
      check({23'h0, er, rd}, {23'h0, e, exp});
   endtask : rchk

   // b is the bit of the event carrier, held for n cycles
   task automatic burst(input int b, input int n);
      @(posedge clk);
      ev <= rx_pm_pkg::rx_events_s'(11'h1 << b);
      repeat (n) @(posedge clk);
      ev <= '0;
   endtask : burst

   // mode 0 zeros, 1 one in eight, 2 alternating from a one
   task automatic bits(input int n, input int mode);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         bit_v <= 1'b1;
         bit_d <= (mode == 0) ? 1'b0 : (mode == 1) ? (k % 8 == 0) : ~k[0];
      end
      @(posedge clk);
      bit_v <= 1'b0;
   endtask : bits

   initial begin
      {psel, penable, pwrite, bit_v, bit_d} = '0;
      paddr  = '0;
      pwdata = '0;
      pstrb  = 4'hf;
      ev     = '0;
      fails  = 0;
      checked = 0;
      rst    = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 16; i <= 32; i++)
         rchk(i[5:0], 8'h00, i == 26);
      $display("test reset_map done");
      xfer(1'b1, rx_pm_pkg::IDX_PATTERN_ERR, 8'hfe);
      burst(10, 3);
      rchk(rx_pm_pkg::IDX_PATTERN_ERR, 8'h01, 1'b0);
      burst(9, 5);
      rchk(rx_pm_pkg::IDX_PATTERN_MF, 8'h05, 1'b0);
      xfer(1'b1, rx_pm_pkg::IDX_PATTERN_ERR, 8'h7e);
      rchk(rx_pm_pkg::IDX_PATTERN_ERR, 8'h7e, 1'b0);
      rchk(rx_pm_pkg::IDX_PATTERN_MF, 8'h00, 1'b0);
      burst(3, 2);
      xfer(1'b1, rx_pm_pkg::IDX_ALIGN_ERR, 8'hff);
      rchk(rx_pm_pkg::IDX_ALIGN_ERR, 8'h02, 1'b0);
      burst(2, 260);
      rchk(rx_pm_pkg::IDX_FAR_END_HI, 8'h01, 1'b0);
      rchk(rx_pm_pkg::IDX_FAR_END_LO, 8'h04, 1'b0);
      burst(1, 258);
      rchk(rx_pm_pkg::IDX_VIOLATION_HI, 8'h01, 1'b0);
      rchk(rx_pm_pkg::IDX_VIOLATION_LO, 8'h02, 1'b0);
      burst(0, 1025);
      rchk(rx_pm_pkg::IDX_CHECKSUM_HI, 8'h00, 1'b0);
      rchk(rx_pm_pkg::IDX_CHECKSUM_LO, 8'h01, 1'b0);
      rchk(rx_pm_pkg::IDX_WRAP_LATCH, 8'h44, 1'b0);
      rchk(rx_pm_pkg::IDX_WRAP_LATCH, 8'h00, 1'b0);
      check(irq, 1'b0);
      xfer(1'b1, rx_pm_pkg::IDX_WRAP_MASK, 8'h40);
      burst(0, 1024);
      @(negedge clk);
      check(irq, 1'b1);
      rchk(rx_pm_pkg::IDX_WRAP_EVENTS, 8'h40, 1'b0);
      @(negedge clk);
      check(irq, 1'b0);
      $display("test counters done");
      for (int i = 0; i < 5; i++) begin
         burst(8 - i, 1);
         rchk(rx_pm_pkg::IDX_ALARM_LATCH, (i < 3) ? 8'h80 >> i : 8'h20 >> i,
              1'b0);
         rchk(rx_pm_pkg::IDX_ALARM_LATCH, 8'h00, 1'b0);
      end
      $display("test alarms done");
      bits(191, 0);
      @(negedge clk);
      check(los, 1'b0);
      bits(1, 0);
      @(negedge clk);
      check(los, 1'b1);
      bits(192, 1);
      @(negedge clk);
      check(los, 1'b0);
      bits(512, 2);
      @(negedge clk);
      check(aux, 1'b1);
      rchk(rx_pm_pkg::IDX_ALARM_LATCH, 8'h18, 1'b0);
      bits(1, 0);
      @(negedge clk);
      check(aux, 1'b0);
      $display("test line done");
      complete_run();
   end
endmodule : e1_rx_perf_monitor_status_test

bind e1_rx_perf_monitor_status e1_rx_pm_chk #(.AW(AW)) chk (
   .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT(RX_BIT),
   .LOSS_OF_SIGNAL(LOSS_OF_SIGNAL), .AUX_PATTERN_SEEN(AUX_PATTERN_SEEN),
   .COUNT_WRAP_IRQ(COUNT_WRAP_IRQ));
